// ===== hbdp_host_model.sv
// Host microcontroller model driving the external memory bus.
`timescale 1ns/1ps
module hbdp_host_model
   import hbdp_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic [DATA_W-1:0] data_out,
   input  wire logic              data_oe,
   output hbdp_bus_t              host_bus,
   output logic [DATA_W-1:0]      data_in
);
   // Bus idles with the strobe high and a read direction.
   initial begin
      host_bus = {16'h0000, 1'b1, 1'b1};
      data_in  = 8'h00;
   end

   // Idle phase with a new address.
   task automatic put(input logic [15:0] a);
      @(posedge ref_clk);
      host_bus <= {a, 1'b1, 1'b1};
   endtask : put

   // One memory cycle; q carries the drive flag and the read byte.
   task automatic cyc(input logic rd, input logic [15:0] a, input logic [7:0] d,
                      output logic [8:0] q);
      @(posedge ref_clk);
      host_bus <= {a, rd, 1'b1};
      @(posedge ref_clk);
      host_bus.data_strobe_low <= 1'b0;
      data_in <= rd ? ~data_in : d;
      @(posedge ref_clk);
      @(negedge ref_clk);
      q = {data_oe, data_out};
      @(posedge ref_clk);
      host_bus.data_strobe_low <= 1'b1;
      // Released lines must not keep the last value.
      data_in <= ~d;
   endtask : cyc
endmodule : hbdp_host_model

// ===== hbdp_pkg.sv
// Shared constants, types and default decoder programming for the host bus decode port.
package hbdp_pkg;

   // Host bus, page register and port widths.
   localparam int ADDR_W   = 16;
   localparam int DATA_W   = 8;
   localparam int PAGE_W   = 4;
   localparam int PORTC_W  = 3;
   localparam int PORTB_W  = 8;

   // Highest address that the host places on the external bus.
   localparam logic [ADDR_W-1:0] EXT_TOP_ADDR = 16'hE7FF;

   // Decoder input bus layout, shared by both arrays.
   localparam int IN_ADDR_LSB  = 0;
   localparam int IN_PAGE_LSB  = 16;
   localparam int IN_RW_BIT    = 20;
   localparam int IN_STRB_BIT  = 21;
   localparam int IN_PORTC_LSB = 22;
   localparam int IN_W         = 25;

   // First array: eight program-memory segments, static RAM and I/O ports.
   localparam int NUM_SEG   = 8;
   localparam int A_SRAM    = 8;
   localparam int A_IO      = 9;
   localparam int A_OUTS    = 10;

   // Second array: four sum-of-product outputs of four terms each.
   localparam int B_OUTS    = 4;
   localparam int B_TERMS   = 4;

   // I/O space offsets, taken from the low address bits.
   localparam int IO_OFS_W            = 4;
   localparam logic [3:0] OFS_PAGE    = 4'h0;
   localparam logic [3:0] OFS_MODE_B  = 4'h1;
   localparam logic [3:0] OFS_PIN_B   = 4'h3;
   localparam logic [3:0] OFS_DIR_B   = 4'h5;
   localparam logic [3:0] OFS_DATA_B  = 4'h7;
   localparam logic [3:0] OFS_PIN_C   = 4'hB;
   localparam logic [3:0] OFS_DIR_C   = 4'hD;
   localparam logic [3:0] OFS_DATA_C  = 4'hF;

   // Reset values.
   localparam logic [PAGE_W-1:0]  PAGE_RST = 4'h0;
   localparam logic [PORTB_W-1:0] B_RST    = 8'h00;
   localparam logic [PORTC_W-1:0] C_RST    = 3'h0;
   localparam logic [DATA_W-1:0]  D_RST    = 8'h00;

   // Default programming: care mask and match value per product term.
   // First array, one term per output.
   localparam logic [A_OUTS*IN_W-1:0] A_CARE = {
      25'h0000FF00, 25'h0000F800,
      25'h000F8000, 25'h000F8000, 25'h000F8000, 25'h000F8000,
      25'h000F8000, 25'h000F8000, 25'h000F8000, 25'h000F8000};
   localparam logic [A_OUTS*IN_W-1:0] A_MATCH = {
      25'h00009000, 25'h00008000,
      25'h00070000, 25'h00060000, 25'h00050000, 25'h00040000,
      25'h00030000, 25'h00020000, 25'h00010000, 25'h00000000};
   // Second array; a term with an all-zero care mask is unused.
   localparam logic [B_TERMS*IN_W-1:0] B_CARE [B_OUTS] = '{
      {75'h0, 25'h0000F000}, {75'h0, 25'h0000F000},
      {75'h0, 25'h0000F000}, {75'h0, 25'h0000F000}};
   localparam logic [B_TERMS*IN_W-1:0] B_MATCH [B_OUTS] = '{
      {75'h0, 25'h0000A000}, {75'h0, 25'h0000B000},
      {75'h0, 25'h0000C000}, {75'h0, 25'h0000D000}};

   // Host bus request as seen on the pins.
   typedef struct packed {
      logic [7:0] high_address_inputs;
      logic [7:0] low_address_inputs;
      logic       rw;
      logic       data_strobe_low;
   } hbdp_bus_t;

   // Selects driven toward memories and external devices, all active low.
   typedef struct packed {
      logic [B_OUTS-1:0]  ext_n;
      logic               io_n;
      logic               sram_n;
      logic [NUM_SEG-1:0] seg_n;
   } hbdp_sel_t;

endpackage : hbdp_pkg

// ===== hbdp_pterm_sum.sv
// Programmable sum of product terms over the shared decoder input bus.
`timescale 1ns/1ps
module hbdp_pterm_sum #(
   parameter int                        W      = 25,
   parameter int                        TERMS  = 1,
   parameter logic [TERMS*W-1:0]        CARE   = '0,
   parameter logic [TERMS*W-1:0]        MATCH  = '0,
   parameter bit                        ALLOW_EMPTY = 1'b1
) (
   input  wire logic [W-1:0] in_bus,
   output logic              hit
);

   // Each input position needs 0, needs 1, or is ignored where the care bit is clear.
   // An all-ignore term is dropped when ALLOW_EMPTY is clear, so spare terms stay quiet.
   always_comb begin
      hit = 1'b0;
      for (int t = 0; t < TERMS; t++) begin
         if ((CARE[t*W +: W] != '0) || ALLOW_EMPTY) begin
            if (((in_bus ^ MATCH[t*W +: W]) & CARE[t*W +: W]) == '0) begin
               hit = 1'b1;
            end
         end
      end
   end

endmodule : hbdp_pterm_sum

// ===== hbdp_top.sv
// Host bus decode port: address decoders, page register and per-bit I/O ports.
`timescale 1ns/1ps
module hbdp_top
   import hbdp_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               nrst,
   input  wire hbdp_bus_t          host_bus,
   input  wire logic [DATA_W-1:0]  data_in,
   output logic [DATA_W-1:0]       data_out,
   output logic                    data_oe,
   input  wire logic               power_down,
   input  wire logic [PORTB_W-1:0] port_b_in,
   output logic [PORTB_W-1:0]      port_b_out,
   output logic [PORTB_W-1:0]      port_b_oe,
   input  wire logic [PORTC_W-1:0] port_c_in,
   output logic [PORTC_W-1:0]      port_c_out,
   output logic [PORTC_W-1:0]      port_c_oe,
   output hbdp_sel_t               sel_n
);

   // Whole module state in one record.
   typedef struct packed {
      logic               strobe_low_q;
      logic               rw_q;
      logic [ADDR_W-1:0]  addr_q;
      logic [DATA_W-1:0]  wdata_q;
      logic               io_hit_q;
      logic [PAGE_W-1:0]  page;
      logic [PORTB_W-1:0] mode_b;
      logic [PORTB_W-1:0] dir_b;
      logic [PORTB_W-1:0] dat_b;
      logic [PORTC_W-1:0] dir_c;
      logic [PORTC_W-1:0] dat_c;
      logic [DATA_W-1:0]  rdata;
      logic               rdata_oe;
      hbdp_sel_t          sel;
      logic [PORTB_W-1:0] pb_out;
      logic [PORTB_W-1:0] pb_oe;
   } hbdp_state_t;

   localparam hbdp_state_t ST_RST = '{
      strobe_low_q : 1'b1,
      rw_q         : 1'b1,
      addr_q       : '0,
      wdata_q      : D_RST,
      io_hit_q     : 1'b0,
      page         : PAGE_RST,
      mode_b       : B_RST,
      dir_b        : B_RST,
      dat_b        : B_RST,
      dir_c        : C_RST,
      dat_c        : C_RST,
      rdata        : D_RST,
      rdata_oe     : 1'b0,
      sel          : '1,
      pb_out       : B_RST,
      pb_oe        : B_RST
   };

   hbdp_state_t         st_reg;
   hbdp_state_t         st_next;
   logic [ADDR_W-1:0]   addr;
   logic [IN_W-1:0]     pad_in;
   logic [A_OUTS-1:0]   a_hit;
   logic [B_OUTS-1:0]   b_hit;
   logic                in_range;
   logic [PORTC_W-1:0]  pc_level;
   logic [IO_OFS_W-1:0] ofs;
   logic [IO_OFS_W-1:0] wofs;
   logic                io_read;
   logic                io_write;
   logic [DATA_W-1:0]   rd_mux;

   // address pins form the address
   // The low pins are address only here, so no address latch is needed.
   assign addr = {host_bus.high_address_inputs, host_bus.low_address_inputs};

   // Port C pins feed the decoders as inputs; when driven, the output level is seen.
   assign pc_level = (st_reg.dir_c & st_reg.dat_c) | (~st_reg.dir_c & port_c_in);

   assign pad_in = {pc_level, host_bus.data_strobe_low, host_bus.rw, st_reg.page, addr};

   assign in_range = (addr <= EXT_TOP_ADDR);

   generate
      for (genvar i = 0; i < A_OUTS; i++) begin : g_pad_a
         hbdp_pterm_sum #(
            .W           (IN_W),
            .TERMS       (1),
            .CARE        (A_CARE[i*IN_W +: IN_W]),
            .MATCH       (A_MATCH[i*IN_W +: IN_W]),
            .ALLOW_EMPTY (1'b1)
         ) u_hbdp_pterm_sum (
            .in_bus (pad_in),
            .hit    (a_hit[i])
         );
      end
      for (genvar j = 0; j < B_OUTS; j++) begin : g_pad_b
         hbdp_pterm_sum #(
            .W           (IN_W),
            .TERMS       (B_TERMS),
            .CARE        (B_CARE[j]),
            .MATCH       (B_MATCH[j]),
            .ALLOW_EMPTY (1'b0)
         ) u_hbdp_pterm_sum (
            .in_bus (pad_in),
            .hit    (b_hit[j])
         );
      end
   endgenerate

   // low strobe with high direction is a read
   // A read is recognised from the live pins so data is ready well before the strobe rises.
   assign io_read = ~host_bus.data_strobe_low & host_bus.rw & a_hit[A_IO]
                    & in_range & ~power_down;

   // write completes on strobe rise
   // Address and data are taken from the low phase, when the host holds them steady.
   assign io_write = st_reg.strobe_low_q == 1'b0 && host_bus.data_strobe_low == 1'b1
                     && st_reg.rw_q == 1'b0 && st_reg.io_hit_q;

   assign ofs  = addr[IO_OFS_W-1:0];
   assign wofs = st_reg.addr_q[IO_OFS_W-1:0];

   // Read multiplexer for the I/O register space; unused offsets read zero.
   always_comb begin
      rd_mux = D_RST;
      unique case (ofs)
         OFS_PAGE:   rd_mux = {{(DATA_W-PAGE_W){1'b0}}, st_reg.page};
         OFS_MODE_B: rd_mux = st_reg.mode_b;
         OFS_PIN_B:  rd_mux = port_b_in;
         OFS_DIR_B:  rd_mux = st_reg.dir_b;
         OFS_DATA_B: rd_mux = st_reg.dat_b;
         OFS_PIN_C:  rd_mux = {{(DATA_W-PORTC_W){1'b0}}, port_c_in};
         OFS_DIR_C:  rd_mux = {{(DATA_W-PORTC_W){1'b0}}, st_reg.dir_c};
         OFS_DATA_C: rd_mux = {{(DATA_W-PORTC_W){1'b0}}, st_reg.dat_c};
         default:    rd_mux = D_RST;
      endcase
   end

   // Next-state logic for the whole module.
   always_comb begin
      st_next = st_reg;

      // Bus sampling; direction is only meaningful during the low phase.
      st_next.strobe_low_q = host_bus.data_strobe_low;
      if (!host_bus.data_strobe_low) begin
         st_next.rw_q     = host_bus.rw;
         st_next.addr_q   = addr;
         st_next.wdata_q  = data_in;
         st_next.io_hit_q = a_hit[A_IO] & in_range & ~power_down;
      end else if (!st_reg.strobe_low_q) begin
         st_next.io_hit_q = 1'b0;
      end

      if (io_write) begin
         unique case (wofs)
            OFS_PAGE:   st_next.page   = st_reg.wdata_q[PAGE_W-1:0];
            OFS_MODE_B: st_next.mode_b = st_reg.wdata_q;
            OFS_DIR_B:  st_next.dir_b  = st_reg.wdata_q;
            OFS_DATA_B: st_next.dat_b  = st_reg.wdata_q;
            OFS_DIR_C:  st_next.dir_c  = st_reg.wdata_q[PORTC_W-1:0];
            OFS_DATA_C: st_next.dat_c  = st_reg.wdata_q[PORTC_W-1:0];
            default:    st_next.page   = st_reg.page;
         endcase
      end

      st_next.rdata_oe = io_read;
      st_next.rdata    = io_read ? rd_mux : D_RST;

      if (power_down || !in_range) begin
         st_next.sel = '1;
      end else begin
         st_next.sel.seg_n  = ~a_hit[NUM_SEG-1:0];
         st_next.sel.sram_n = ~a_hit[A_SRAM];
         st_next.sel.io_n   = ~a_hit[A_IO];
         st_next.sel.ext_n  = ~b_hit;
      end

      // port B bit is I/O or a select
      // Select mode drives each bit from a second-array output; those are always driven.
      for (int k = 0; k < PORTB_W; k++) begin
         st_next.pb_oe[k]  = st_reg.mode_b[k] | st_reg.dir_b[k];
         st_next.pb_out[k] = st_reg.mode_b[k] ? st_next.sel.ext_n[k % B_OUTS]
                                              : st_reg.dat_b[k];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         st_reg <= ST_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state record.
   assign data_out   = st_reg.rdata;
   assign data_oe    = st_reg.rdata_oe;
   assign sel_n      = st_reg.sel;
   assign port_b_out = st_reg.pb_out;
   assign port_b_oe  = st_reg.pb_oe;
   assign port_c_out = st_reg.dat_c;
   assign port_c_oe  = st_reg.dir_c;

endmodule : hbdp_top

// ===== hbdp_top_chk.sv
// Assertion checker on the decode port pins.
`timescale 1ns/1ps
module hbdp_top_chk
   import hbdp_pkg::*;
(
   input wire logic              ref_clk,
   input wire logic              nrst,
   input wire hbdp_bus_t         host_bus,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic              data_oe,
   input wire logic              power_down,
   input wire hbdp_sel_t         sel_n
);
   logic [15:0] addr;

   // Full address as the decoders see it.
   assign addr = {host_bus.high_address_inputs, host_bus.low_address_inputs};

   // Selects answer the inputs of the previous edge; checks pause in reset, except a_rst_desel.
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   a_pd_desel: assert property (power_down |=> &sel_n && !data_oe)
      else $error("output active in power-down");
   a_range_off: assert property (addr > EXT_TOP_ADDR |=> &sel_n)
      else $error("select above external range");
   a_rst_desel: assert property (disable iff (1'b0) !nrst |=> &sel_n && !data_oe)
      else $error("output active after reset");
   a_sram_hit: assert property (addr[15:11] == 5'h10 && !power_down |=> !sel_n.sram_n)
      else $error("static RAM not selected");
   a_seg_one: assert property (!addr[15] |=> $onehot0(~sel_n.seg_n) && sel_n.sram_n)
      else $error("segment selects overlap");
   a_ext_pick: assert property (addr[15:12] inside {[4'hA:4'hD]} && !power_down
      |=> sel_n.ext_n == ~(4'h1 << ($past(addr[13:12]) ^ 2'h2)))
      else $error("wrong external select");
   a_rd_cause: assert property (data_oe
      |-> $past(host_bus.rw) && !$past(host_bus.data_strobe_low))
      else $error("data driven outside a read");
   a_rd_drive: assert property (!host_bus.data_strobe_low && host_bus.rw
      && addr[15:8] == 8'h90 && !power_down |=> data_oe)
      else $error("read not answered");
endmodule : hbdp_top_chk

// ===== hbdp_top_test.sv
// Self-checking bench for the host bus decode port.
`timescale 1ns/1ps
module hbdp_top_test
   import hbdp_pkg::*;
;
   logic        ref_clk, nrst, power_down;
   hbdp_bus_t   host_bus;
   hbdp_sel_t   sel_n;
   logic [7:0]  data_in, data_out, b_out, b_oe, b_ext;
   logic [2:0]  c_out, c_oe, c_ext;
   logic        data_oe;
   logic [8:0]  q;
   wire  [7:0]  b_pin;
   wire  [2:0]  c_pin;
   int          err_count = 0;
   int          checked = 0;

   // Pin level: the port where it drives, the outside world elsewhere.
   assign b_pin = (b_out & b_oe) | (b_ext & ~b_oe);
   assign c_pin = (c_out & c_oe) | (c_ext & ~c_oe);

   hbdp_top u_hbdp_top (.ref_clk, .nrst, .host_bus, .data_in, .data_out, .data_oe,
      .power_down, .port_b_in(b_pin), .port_b_out(b_out), .port_b_oe(b_oe),
      .port_c_in(c_pin), .port_c_out(c_out), .port_c_oe(c_oe), .sel_n);
   hbdp_host_model u_hbdp_host_model (.ref_clk, .data_out, .data_oe, .host_bus, .data_in);

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic stop_test;
      if (err_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test

   // Select pattern from the default map; pages 8 to 15 hit no segment.
   function automatic logic [15:0] exp_sel(input logic [15:0] a, input logic [3:0] pg);
      logic [15:0] s;
      s = 16'h3FFF;
      if (a <= EXT_TOP_ADDR) begin
         if (!a[15] && !pg[3]) s[pg] = 1'b0;
         if (a[15:11] == 5'h10) s[8] = 1'b0;
         if (a[15:8] == 8'h90) s[9] = 1'b0;
         if (a[15:12] inside {[4'hA:4'hD]}) s[a[15:12]] = 1'b0;
      end
      return s;
   endfunction : exp_sel

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      u_hbdp_host_model.cyc(1'b0, a, d, q);
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [8:0] e);
      u_hbdp_host_model.cyc(1'b1, a, 8'h00, q);
      chk(16'(q), 16'(e));
   endtask : rd

   task automatic t_reset;
      @(negedge ref_clk);
      chk(16'(sel_n), 16'h3FFF);
      chk({b_oe, 5'h00, c_oe}, 16'h0000);
   endtask : t_reset

   // Edges of the segment, static RAM and external ranges, one I/O address, plus addresses past the external top.
   task automatic t_decode(input logic [3:0] pg);
      logic [15:0] a [11] = '{16'h0000, 16'h7FFF, 16'h8000, 16'h87FF, 16'h9000,
         16'hA000, 16'hB123, 16'hC000, 16'hDFFF, 16'hE800, 16'hF000};
      foreach (a[i]) begin
         u_hbdp_host_model.put(a[i]);
         @(posedge ref_clk);
         @(negedge ref_clk);
         chk(16'(sel_n), exp_sel(a[i], pg));
      end
   endtask : t_decode

   task automatic t_page;
      wr(16'h9000, 8'h05);
      t_decode(4'h5);
      wr(16'h9000, 8'h09);
      t_decode(4'h9);
   endtask : t_page

   // Per-bit direction; the pin register ignores writes.
   task automatic t_ports;
      @(posedge ref_clk);
      b_ext <= 8'h3C;
      c_ext <= 3'h6;
      wr(16'h9005, 8'hF0);
      wr(16'h9007, 8'hA5);
      wr(16'h900D, 8'h05);
      wr(16'h900F, 8'h03);
      wr(16'h9003, 8'hFF);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({b_oe, b_out & b_oe}, 16'hF0A0);
      chk({5'h00, c_oe, 5'h00, c_out & c_oe}, 16'h0501);
      rd(16'h9005, 9'h1F0);
      rd(16'h9007, 9'h1A5);
      rd(16'h9003, 9'h1AC);
      rd(16'h900B, 9'h103);
      rd(16'h9002, 9'h100);
      // Select mode on the low nibble routes second-array outputs to the pins.
      wr(16'h9001, 8'h0F);
      u_hbdp_host_model.put(16'hA000);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk({b_oe, b_out}, 16'hFFAE);
      rd(16'h9001, 9'h10F);
      rd(16'h9000, 9'h109);
      rd(16'h900D, 9'h105);
      rd(16'h900F, 9'h103);
   endtask : t_ports

   // Power-down drops selects and blocks port access.
   task automatic t_pd;
      @(posedge ref_clk);
      power_down <= 1'b1;
      u_hbdp_host_model.put(16'h8000);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(16'(sel_n), 16'h3FFF);
      wr(16'h9005, 8'h00);
      rd(16'h9005, 9'h000);
      @(posedge ref_clk);
      power_down <= 1'b0;
      rd(16'h9005, 9'h1F0);
   endtask : t_pd

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Main sequence; the run ends only through stop_test.
   initial begin
      nrst       = 1'b0;
      power_down = 1'b0;
      b_ext      = 8'h00;
      c_ext      = 3'h0;
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset;
      t_decode(4'h0);
      t_page;
      t_ports;
      t_pd;
      stop_test;
   end

   // The tests need well under a thousand cycles; this margin catches a hang.
   initial begin
      #(5000 * 50);
      err_count++;
      stop_test;
   end
endmodule : hbdp_top_test

bind hbdp_top hbdp_top_chk u_hbdp_top_chk (.ref_clk, .nrst, .host_bus, .data_out,
   .data_oe, .power_down, .sel_n);
